// ==== core/fead_defs.svh ====
// constants of the flash extended address decoder: opcodes, offsets, field positions
// assumes inclusion by the decoder top and the monitor
`ifndef FEAD_DEFS_SVH
`define FEAD_DEFS_SVH

// dedicated 32-bit address opcodes
`define FEAD_OP4_NORMAL_READ   8'h13
`define FEAD_OP4_FAST_READ     8'h0C
`define FEAD_OP4_DUAL_IO_READ  8'hBC
`define FEAD_OP4_DUAL_OUT_READ 8'h3C
`define FEAD_OP4_QUAD_IO_READ  8'hEC
`define FEAD_OP4_QUAD_OUT_READ 8'h6C
`define FEAD_OP4_DDR_READ      8'h0E
`define FEAD_OP4_DUAL_DDR_READ 8'hBE
`define FEAD_OP4_QUAD_DDR_READ 8'hEE
`define FEAD_OP4_PAGE_PROG     8'h12
`define FEAD_OP4_QUAD_PROG_A   8'h34
`define FEAD_OP4_QUAD_PROG_B   8'h3E
`define FEAD_OP4_SECTOR_ERASE  8'h21
`define FEAD_OP4_BLOCK_ERASE_S 8'h5C
`define FEAD_OP4_BLOCK_ERASE_L 8'hDC
`define FEAD_OP4_SECTOR_UNLOCK 8'h25
`define FEAD_OP4_RD_VOL_LOCK   8'hE0
`define FEAD_OP4_WR_VOL_LOCK   8'hE1
`define FEAD_OP4_RD_PER_LOCK   8'hE2
`define FEAD_OP4_PG_PER_LOCK   8'hE3

// standard opcodes, address width follows the mode
`define FEAD_OP_NORMAL_READ    8'h03
`define FEAD_OP_FAST_READ      8'h0B
`define FEAD_OP_DUAL_IO_READ   8'hBB
`define FEAD_OP_DUAL_OUT_READ  8'h3B
`define FEAD_OP_QUAD_IO_READ   8'hEB
`define FEAD_OP_QUAD_OUT_READ  8'h6B
`define FEAD_OP_DDR_READ       8'h0D
`define FEAD_OP_DUAL_DDR_READ  8'hBD
`define FEAD_OP_QUAD_DDR_READ  8'hED
`define FEAD_OP_PAGE_PROG      8'h02
`define FEAD_OP_QUAD_PROG_A    8'h32
`define FEAD_OP_QUAD_PROG_B    8'h38
`define FEAD_OP_SECTOR_ERASE_A 8'hD7
`define FEAD_OP_SECTOR_ERASE_B 8'h20
`define FEAD_OP_BLOCK_ERASE_S  8'h52
`define FEAD_OP_BLOCK_ERASE_L  8'hD8
`define FEAD_OP_SECTOR_UNLOCK  8'h26
`define FEAD_OP_RD_VOL_LOCK    8'hFA
`define FEAD_OP_WR_VOL_LOCK    8'hFB
`define FEAD_OP_RD_PER_LOCK    8'hFC
`define FEAD_OP_PG_PER_LOCK    8'hFD

// register byte offsets
`define FEAD_OFF_BANK          8'h00
`define FEAD_OFF_STATUS        8'h04
`define FEAD_OFF_CTRL          8'h08
`define FEAD_OFF_LAST_ADDR     8'h0C

// bank register fields and reset
`define FEAD_BANK_WIDE_BIT     7
`define FEAD_BANK_SEL_BIT      0
`define FEAD_BANK_RESET        8'h00

// link framing counts and last array address
`define FEAD_OPCODE_BITS       6'd8
`define FEAD_ADDR3_BITS        6'd24
`define FEAD_ADDR4_BITS        6'd32
`define FEAD_ARRAY_LAST        32'h01FFFFFF

// axi responses
`define FEAD_RESP_OKAY         2'b00
`define FEAD_RESP_DECERR       2'b11
`endif

// ==== core/fead_pkg.sv ====
// types shared by the extended address decoder modules
// enum codes are literals here; fead_defs.svh is not included
package fead_pkg;
  typedef enum logic [2:0] {
    FEAD_KIND_NONE    = 3'h0,
    FEAD_KIND_READ    = 3'h1,
    FEAD_KIND_PROGRAM = 3'h2,
    FEAD_KIND_ERASE   = 3'h3,
    FEAD_KIND_PROTECT = 3'h4,
    FEAD_KIND_ENTER4  = 3'h5
  } fead_kind_t;

  typedef enum logic [3:0] {
    FEAD_ST_IDLE   = 4'b0001,
    FEAD_ST_OPCODE = 4'b0010,
    FEAD_ST_ADDR   = 4'b0100,
    FEAD_ST_DATA   = 4'b1000
  } fead_state_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [31:0] addr;
    logic        wide;
    fead_kind_t  kind;
  } fead_cmd_t;

  typedef struct packed {
    logic       cs_n;
    logic       rise;
    logic       fall;
    logic [3:0] io;
  } fead_link_t;
endpackage

// ==== core/fead_link_sampler.sv ====
// synchronises the serial link pins and finds serial clock edges
// assumes link pins are asynchronous to clock; sck is much slower than clock
`timescale 1ns/100ps
module fead_link_sampler
  import fead_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       chip_sel_n,
  input  wire logic       serial_clk,
  input  wire logic [3:0] serial_io,
  output fead_link_t      link
);
  logic [5:0] meta_reg;
  logic [5:0] sync_reg;
  logic       sck_prev_reg;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg     <= 6'h3F;
      sync_reg     <= 6'h3F;
      sck_prev_reg <= 1'b1;
    end else begin
      meta_reg     <= {chip_sel_n, serial_clk, serial_io};
      sync_reg     <= meta_reg;
      sck_prev_reg <= sync_reg[4];
    end
  end

  // edges are read only from the second stage onward
  assign link.cs_n = sync_reg[5];
  assign link.rise = sync_reg[4] & ~sck_prev_reg & ~sync_reg[5];
  assign link.fall = ~sync_reg[4] & sck_prev_reg & ~sync_reg[5];
  assign link.io   = sync_reg[3:0];
endmodule

// ==== core/fead_decoder_top.sv ====
// command decoder and address width selection for a 256 Mbit serial flash
// assumes a host drives chip select, serial clock and io; software uses AXI4-Lite
`timescale 1ns/100ps
`include "fead_defs.svh"
module fead_decoder_top
  import fead_pkg::*;
#(
  parameter logic [7:0] ENTER4_OPCODE = 8'h00
)(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        chip_sel_n,
  input  wire logic        serial_clk,
  input  wire logic [3:0]  serial_io,
  input  wire logic        data_byte_done,
  output fead_cmd_t        cmd,
  output logic             cmd_valid,
  output logic [31:0]      seq_addr,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  fead_link_t  link;
  fead_state_t state_reg;
  fead_state_t state_next;
  fead_cmd_t   cmd_reg;
  fead_kind_t  op_kind;
  logic [7:0]  bank_select_register;
  logic        four_byte_reg;
  logic [31:0] shift_reg;
  logic [31:0] shift_next;
  logic [5:0]  bit_cnt_reg;
  logic [5:0]  bit_cnt_next;
  logic [2:0]  lanes_reg;
  logic        ddr_reg;
  logic        wide_cur_reg;
  logic [7:0]  opcode_reg;
  logic        cmd_valid_reg;
  logic [31:0] seq_addr_reg;
  logic [7:0]  last_opcode_reg;

  fead_link_sampler u_sampler (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .chip_sel_n (chip_sel_n),
    .serial_clk (serial_clk),
    .serial_io  (serial_io),
    .link       (link)
  );

  // opcode classification
  logic [7:0] op_byte;
  logic       op_dedicated;
  logic       op_standard;
  logic       op_enter4;
  logic       op_dual;
  logic       op_quad;
  logic       op_ddr;
  logic       op_read;
  logic       op_prog;
  logic       op_erase;
  logic       op_prot;

  assign op_byte = {shift_reg[6:0], link.io[0]};

  assign op_dedicated = (op_byte == `FEAD_OP4_NORMAL_READ) || (op_byte == `FEAD_OP4_FAST_READ)
    || (op_byte == `FEAD_OP4_DUAL_IO_READ) || (op_byte == `FEAD_OP4_DUAL_OUT_READ)
    || (op_byte == `FEAD_OP4_QUAD_IO_READ) || (op_byte == `FEAD_OP4_QUAD_OUT_READ)
    || (op_byte == `FEAD_OP4_DDR_READ) || (op_byte == `FEAD_OP4_DUAL_DDR_READ)
    || (op_byte == `FEAD_OP4_QUAD_DDR_READ) || (op_byte == `FEAD_OP4_PAGE_PROG)
    || (op_byte == `FEAD_OP4_QUAD_PROG_A) || (op_byte == `FEAD_OP4_QUAD_PROG_B)
    || (op_byte == `FEAD_OP4_SECTOR_ERASE) || (op_byte == `FEAD_OP4_BLOCK_ERASE_S)
    || (op_byte == `FEAD_OP4_BLOCK_ERASE_L) || (op_byte == `FEAD_OP4_SECTOR_UNLOCK)
    || (op_byte == `FEAD_OP4_RD_VOL_LOCK) || (op_byte == `FEAD_OP4_WR_VOL_LOCK)
    || (op_byte == `FEAD_OP4_RD_PER_LOCK) || (op_byte == `FEAD_OP4_PG_PER_LOCK);

  assign op_standard = (op_byte == `FEAD_OP_NORMAL_READ) || (op_byte == `FEAD_OP_FAST_READ)
    || (op_byte == `FEAD_OP_DUAL_IO_READ) || (op_byte == `FEAD_OP_DUAL_OUT_READ)
    || (op_byte == `FEAD_OP_QUAD_IO_READ) || (op_byte == `FEAD_OP_QUAD_OUT_READ)
    || (op_byte == `FEAD_OP_DDR_READ) || (op_byte == `FEAD_OP_DUAL_DDR_READ)
    || (op_byte == `FEAD_OP_QUAD_DDR_READ) || (op_byte == `FEAD_OP_PAGE_PROG)
    || (op_byte == `FEAD_OP_QUAD_PROG_A) || (op_byte == `FEAD_OP_QUAD_PROG_B)
    || (op_byte == `FEAD_OP_SECTOR_ERASE_A) || (op_byte == `FEAD_OP_SECTOR_ERASE_B)
    || (op_byte == `FEAD_OP_BLOCK_ERASE_S) || (op_byte == `FEAD_OP_BLOCK_ERASE_L)
    || (op_byte == `FEAD_OP_SECTOR_UNLOCK) || (op_byte == `FEAD_OP_RD_VOL_LOCK)
    || (op_byte == `FEAD_OP_WR_VOL_LOCK) || (op_byte == `FEAD_OP_RD_PER_LOCK)
    || (op_byte == `FEAD_OP_PG_PER_LOCK);

  assign op_enter4 = (op_byte == ENTER4_OPCODE);

  // opcode picks the address lane count
  assign op_dual = (op_byte == `FEAD_OP4_DUAL_IO_READ) || (op_byte == `FEAD_OP_DUAL_IO_READ)
    || (op_byte == `FEAD_OP4_DUAL_DDR_READ) || (op_byte == `FEAD_OP_DUAL_DDR_READ);
  assign op_quad = (op_byte == `FEAD_OP4_QUAD_IO_READ) || (op_byte == `FEAD_OP_QUAD_IO_READ)
    || (op_byte == `FEAD_OP4_QUAD_DDR_READ) || (op_byte == `FEAD_OP_QUAD_DDR_READ);
  assign op_ddr = (op_byte == `FEAD_OP4_DDR_READ) || (op_byte == `FEAD_OP_DDR_READ)
    || (op_byte == `FEAD_OP4_DUAL_DDR_READ) || (op_byte == `FEAD_OP_DUAL_DDR_READ)
    || (op_byte == `FEAD_OP4_QUAD_DDR_READ) || (op_byte == `FEAD_OP_QUAD_DDR_READ);

  assign op_read = (op_byte == `FEAD_OP4_NORMAL_READ) || (op_byte == `FEAD_OP4_FAST_READ)
    || (op_byte == `FEAD_OP4_DUAL_OUT_READ) || (op_byte == `FEAD_OP4_QUAD_OUT_READ)
    || (op_byte == `FEAD_OP_NORMAL_READ) || (op_byte == `FEAD_OP_FAST_READ)
    || (op_byte == `FEAD_OP_DUAL_OUT_READ) || (op_byte == `FEAD_OP_QUAD_OUT_READ)
    || op_dual || op_quad || op_ddr;
  assign op_prog = (op_byte == `FEAD_OP4_PAGE_PROG) || (op_byte == `FEAD_OP4_QUAD_PROG_A)
    || (op_byte == `FEAD_OP4_QUAD_PROG_B) || (op_byte == `FEAD_OP_PAGE_PROG)
    || (op_byte == `FEAD_OP_QUAD_PROG_A) || (op_byte == `FEAD_OP_QUAD_PROG_B);
  assign op_erase = (op_byte == `FEAD_OP4_SECTOR_ERASE) || (op_byte == `FEAD_OP4_BLOCK_ERASE_S)
    || (op_byte == `FEAD_OP4_BLOCK_ERASE_L) || (op_byte == `FEAD_OP_SECTOR_ERASE_A)
    || (op_byte == `FEAD_OP_SECTOR_ERASE_B) || (op_byte == `FEAD_OP_BLOCK_ERASE_S)
    || (op_byte == `FEAD_OP_BLOCK_ERASE_L);
  assign op_prot = (op_dedicated || op_standard) && !op_read && !op_prog && !op_erase;

  assign op_kind = op_read  ? FEAD_KIND_READ :
                   op_prog  ? FEAD_KIND_PROGRAM :
                   op_erase ? FEAD_KIND_ERASE :
                   op_prot  ? FEAD_KIND_PROTECT :
                   op_enter4 ? FEAD_KIND_ENTER4 : FEAD_KIND_NONE;

  // address width in effect
  logic wide_address_enable;
  logic op_wide;

  assign wide_address_enable = bank_select_register[`FEAD_BANK_WIDE_BIT];
  assign op_wide = op_dedicated || wide_address_enable || four_byte_reg;

  // link edges and address shifting
  logic       opcode_edge;
  logic       addr_edge;
  logic [3:0] lane_bits;
  logic [5:0] addr_bits;
  logic       opcode_done;
  logic       addr_done;

  assign opcode_edge = (state_reg == FEAD_ST_OPCODE) && link.rise;
  // a double rate address starts on a rise; the fall closing the opcode carries no data
  assign addr_edge   = (state_reg == FEAD_ST_ADDR)
                       && (link.rise || (ddr_reg && link.fall && (bit_cnt_reg != 6'd0)));
  assign lane_bits   = (lanes_reg == 3'd4) ? link.io :
                       (lanes_reg == 3'd2) ? {2'b00, link.io[1:0]} : {3'b000, link.io[0]};
  assign addr_bits   = wide_cur_reg ? `FEAD_ADDR4_BITS : `FEAD_ADDR3_BITS;
  assign opcode_done = opcode_edge && (bit_cnt_reg == `FEAD_OPCODE_BITS - 6'd1);
  assign addr_done   = addr_edge && (bit_cnt_reg + {3'b000, lanes_reg} == addr_bits);

  // most significant bits shift in first
  assign shift_next = (lanes_reg == 3'd4) ? {shift_reg[27:0], lane_bits} :
                      (lanes_reg == 3'd2) ? {shift_reg[29:0], lane_bits[1:0]} :
                      {shift_reg[30:0], lane_bits[0]};

  // start address formation
  logic [31:0] start_addr;
  logic [31:0] narrow_addr;

  // bank chooses one 16 Mbyte window
  // only bank bit 0 reaches the array
  assign narrow_addr = {7'h00, bank_select_register[`FEAD_BANK_SEL_BIT], shift_next[23:0]};
  // a full 32-bit address ignores bank
  assign start_addr  = wide_cur_reg ? shift_next : narrow_addr;

  always_comb begin
    state_next   = state_reg;
    bit_cnt_next = bit_cnt_reg;
    if (link.cs_n) begin
      state_next   = FEAD_ST_IDLE;
      bit_cnt_next = 6'd0;
    end else begin
      case (state_reg)
        FEAD_ST_IDLE: begin
          state_next   = FEAD_ST_OPCODE;
          bit_cnt_next = 6'd0;
        end
        FEAD_ST_OPCODE: begin
          if (opcode_done) begin
            bit_cnt_next = 6'd0;
            state_next   = (op_dedicated || op_standard) ? FEAD_ST_ADDR : FEAD_ST_DATA;
          end else if (opcode_edge) begin
            bit_cnt_next = bit_cnt_reg + 6'd1;
          end
        end
        FEAD_ST_ADDR: begin
          if (addr_done) begin
            state_next = FEAD_ST_DATA;
          end else if (addr_edge) begin
            bit_cnt_next = bit_cnt_reg + {3'b000, lanes_reg};
          end
        end
        FEAD_ST_DATA: begin
          state_next = FEAD_ST_DATA;
        end
        default: begin
          state_next   = FEAD_ST_IDLE;
          bit_cnt_next = 6'd0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg   <= FEAD_ST_IDLE;
      bit_cnt_reg <= 6'd0;
    end else begin
      state_reg   <= state_next;
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      shift_reg    <= 32'h00000000;
      lanes_reg    <= 3'd1;
      ddr_reg      <= 1'b0;
      wide_cur_reg <= 1'b0;
      opcode_reg   <= 8'h00;
    end else if (state_reg == FEAD_ST_IDLE) begin
      shift_reg <= 32'h00000000;
      lanes_reg <= 3'd1;
      ddr_reg   <= 1'b0;
    end else if (opcode_done) begin
      shift_reg    <= 32'h00000000;
      lanes_reg    <= op_quad ? 3'd4 : (op_dual ? 3'd2 : 3'd1);
      ddr_reg      <= op_ddr;
      wide_cur_reg <= op_wide;
      opcode_reg   <= op_byte;
    end else if (opcode_edge || addr_edge) begin
      shift_reg <= (state_reg == FEAD_ST_OPCODE) ? {shift_reg[30:0], link.io[0]} : shift_next;
    end
  end

  // decoded command handoff
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_reg         <= '0;
      cmd_valid_reg   <= 1'b0;
      last_opcode_reg <= 8'h00;
    end else begin
      cmd_valid_reg <= addr_done;
      if (addr_done) begin
        cmd_reg.opcode  <= opcode_reg;
        cmd_reg.addr    <= start_addr;
        cmd_reg.wide    <= wide_cur_reg;
        last_opcode_reg <= opcode_reg;
      end
      if (opcode_done) begin
        cmd_reg.kind <= op_kind;
      end
    end
  end

  // sequential address for the data phase
  // streams across banks and wraps only at array end
  // bank is not consulted after the start
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      seq_addr_reg <= 32'h00000000;
    end else if (addr_done) begin
      seq_addr_reg <= start_addr;
    end else if (data_byte_done && state_reg == FEAD_ST_DATA) begin
      seq_addr_reg <= (seq_addr_reg >= `FEAD_ARRAY_LAST) ? 32'h00000000 : seq_addr_reg + 32'd1;
    end
  end

  // register bus
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        do_write;
  logic        do_read;
  logic        wr_bank;
  logic        wr_ctrl;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign do_read  = s_axi_arvalid && !rvalid_reg;
  assign wr_bank  = do_write && (awaddr_reg == `FEAD_OFF_BANK) && wstrb_reg[0];
  assign wr_ctrl  = do_write && (awaddr_reg == `FEAD_OFF_CTRL) && wstrb_reg[0];
  assign wr_hit   = (awaddr_reg == `FEAD_OFF_BANK) || (awaddr_reg == `FEAD_OFF_CTRL);
  assign rd_hit   = (s_axi_araddr == `FEAD_OFF_BANK) || (s_axi_araddr == `FEAD_OFF_STATUS)
                    || (s_axi_araddr == `FEAD_OFF_LAST_ADDR);
  assign status_word = {12'h000, ~link.cs_n, op_wide_now(), four_byte_reg, 1'b0,
                        last_opcode_reg, 8'h00};
  assign rd_word  = (s_axi_araddr == `FEAD_OFF_BANK)   ? {24'h000000, bank_select_register} :
                    (s_axi_araddr == `FEAD_OFF_STATUS) ? status_word :
                    (s_axi_araddr == `FEAD_OFF_LAST_ADDR) ? cmd_reg.addr : 32'h00000000;

  function automatic logic op_wide_now();
    return wide_address_enable || four_byte_reg;
  endfunction

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `FEAD_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `FEAD_RESP_OKAY;
    end else begin
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? `FEAD_RESP_OKAY : `FEAD_RESP_DECERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (do_read) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_word;
        rresp_reg  <= rd_hit ? `FEAD_RESP_OKAY : `FEAD_RESP_DECERR;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // mode state: bank register and four-byte flag
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bank_select_register <= `FEAD_BANK_RESET;
      four_byte_reg        <= 1'b0;
    end else begin
      if (wr_bank) begin
        bank_select_register <= wdata_reg[7:0];
      end
      // enter command only while enable clear
      if (opcode_done && op_enter4 && !wide_address_enable) begin
        four_byte_reg <= 1'b1;
      end else if (wr_ctrl && wdata_reg[0]) begin
        four_byte_reg <= 1'b0;
      end
    end
  end

  // aw and w are accepted one cycle after valid, each while nothing is held
  logic awready_reg;
  logic wready_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
    end else begin
      awready_reg <= s_axi_awvalid && !aw_held_reg && !awready_reg;
      wready_reg  <= s_axi_wvalid && !w_held_reg && !wready_reg;
    end
  end

  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign cmd           = cmd_reg;
  assign cmd_valid     = cmd_valid_reg;
  assign seq_addr      = seq_addr_reg;
endmodule

// ==== dv/fead_monitor.sv ====
// port checks of the address decoder
// assumes one clock domain; bound to the top below
`timescale 1ns/100ps
`include "fead_defs.svh"
module fead_monitor
  import fead_pkg::*;
(
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire fead_cmd_t   cmd,
  input wire logic        cmd_valid,
  input wire logic [31:0] seq_addr,
  input wire logic        data_byte_done,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking mc @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic ded;
  logic last;
  assign ded = cmd.opcode inside {8'h13, 8'h0C, 8'hBC, 8'h3C, 8'hEC, 8'h6C, 8'h0E, 8'hBE, 8'hEE,
    8'h12, 8'h34, 8'h3E, 8'h21, 8'h5C, 8'hDC, 8'h25, 8'hE0, 8'hE1, 8'hE2, 8'hE3};
  assign last = seq_addr == `FEAD_ARRAY_LAST;
  one_pulse_a: assert property (cmd_valid |=> !cmd_valid)
    else $error("strobe held");
  ded_wide_a: assert property (cmd_valid && ded |-> cmd.wide)
    else $error("dedicated not wide");
  narrow_top_a: assert property (cmd_valid && !cmd.wide |-> cmd.addr[31:25] == 7'h00)
    else $error("narrow above array");
  seq_step_a: assert property (data_byte_done && !last |=> seq_addr == $past(seq_addr) + 32'h1)
    else $error("no step");
  seq_wrap_a: assert property (data_byte_done && last |=> seq_addr == 32'h0)
    else $error("no wrap");
  seq_hold_a: assert property (
    !data_byte_done && !cmd_valid ##1 !cmd_valid [*2] |-> $past(seq_addr) == $past(seq_addr, 2))
    else $error("address moved");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
  cover property (cmd_valid && cmd.wide);
  cover property (cmd_valid && !cmd.wide);
  cover property (data_byte_done && last);
endmodule
bind fead_decoder_top fead_monitor u_mon (.clock, .sys_rst, .cmd, .cmd_valid, .seq_addr,
  .data_byte_done, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready);

// ==== dv/fead_host_model.sv ====
// host controller on the serial link
// assumes mode 0 and a 400 ns link period; link clock rests low
`timescale 1ns/100ps
module fead_host_model (
  output logic       chip_sel_n,
  output logic       serial_clk,
  output logic [3:0] serial_io
);
  initial begin
    chip_sel_n = 1'b1;
    serial_clk = 1'b0;
    serial_io  = 4'h5;
  end
  task automatic frame(input logic [7:0] op, input logic [31:0] a, input int nb);
    logic [31:0] sh;
    int          ln;
    logic        ddr;
    ln  = op inside {8'hBB, 8'hBC, 8'hBD, 8'hBE} ? 2 : 1;
    if (op inside {8'hEB, 8'hEC, 8'hED, 8'hEE}) ln = 4;
    ddr = op inside {8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE};
    sh  = a << (32 - nb);
    // keep pin changes off the system clock edge
    #10;
    chip_sel_n = 1'b0;
    for (int i = 0; i < 8 + nb / ln; i++) begin
      serial_io = i < 8 ? {3'h0, op[7 - i]} : 4'(sh[31:28] >> (4 - ln));
      if (i >= 8) sh = sh << ln;
      #100 serial_clk = ~serial_clk;
      // double rate address uses both edges
      if (!ddr || i < 8) #200 serial_clk = 1'b0;
      #100;
    end
    #100 chip_sel_n = 1'b1;
    // released lines must not keep the last bit
    serial_io = ~serial_io;
    #400;
  endtask
endmodule

// ==== dv/flash_extended_address_decode_tb.sv ====
// self-checking bench of the address decoder
// assumes the host model on the link; registers over AXI4-Lite
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module flash_extended_address_decode_tb;
  import fead_pkg::*;
  localparam logic [7:0] ENTER4 = 8'hA5; // arbitrary
  localparam logic [0:40][7:0] OPS = {160'h130CBC3CEC6C0EBEEE12343E215CDC25E0E1E2E3,
    168'h030BBB3BEB6B0DBDED023238D72052D826FAFBFCFD};
  logic        clock = 1'b0, sys_rst = 1'b1, data_byte_done = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seq_addr, rdat;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cmd_valid, chip_sel_n, serial_clk;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0]  serial_io;
  fead_cmd_t   cmd, got;
  int          n_fail = 0, check_count = 0, n_cmd = 0;
  fead_decoder_top #(.ENTER4_OPCODE(ENTER4)) DUT (.clock, .sys_rst, .chip_sel_n, .serial_clk,
    .serial_io, .data_byte_done, .cmd, .cmd_valid, .seq_addr, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  fead_host_model host (.chip_sel_n, .serial_clk, .serial_io);
  always #25 clock = ~clock;
  always @(posedge clock) begin
    if (cmd_valid) begin
      got   <= cmd;
      n_cmd <= n_cmd + 1;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clock); while (!s_axi_rvalid);
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b0;
    rdat = s_axi_rdata;
    rsp  = s_axi_rresp;
  endtask
  function automatic fead_kind_t kind_of(int i);
    int j;
    j = i < 20 ? i : i - 20;
    return fead_kind_t'(3'(j < 9 ? 1 : j < 12 ? 2 : j < 15 + i / 20 ? 3 : 4));
  endfunction
  task automatic send(input logic [7:0] op, input logic [31:0] a, e, input int nb,
                      input fead_kind_t k);
    int n0;
    n0 = n_cmd;
    host.frame(op, a, nb);
    `CHK("frames", n0 + 1, n_cmd)
    `CHK("cmd", {op, e, nb == 32, k}, got)
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_regs;
    rd(8'h00);
    `CHK("bank reset", 32'h0, rdat)
    wr(8'h10, 32'h1);
    `CHK("wr unmapped", 2'h3, rsp)
    rd(8'h10);
    `CHK("rd unmapped", 2'h3, rsp)
    wr(8'h00, 32'h81);
    rd(8'h00);
    `CHK("bank rw", 32'h81, rdat)
  endtask
  task automatic t_ded_ops;
    wr(8'h00, 32'h1);
    for (int i = 0; i < 20; i++) begin
      send(OPS[i], 32'h00A55A00 + i, 32'h00A55A00 + i, 32, kind_of(i));
    end
  endtask
  task automatic t_std_ops;
    logic [31:0] a;
    for (int w = 0; w < 2; w++) begin
      for (int i = 20; i < 41; i++) begin
        a = 32'h01C33C00 + i;
        wr(8'h00, {24'h0, w[0], 6'h0, i[0]});
        if (w) send(OPS[i], a, a, 32, kind_of(i));
        else send(OPS[i], a, {7'h0, i[0], a[23:0]}, 24, kind_of(i));
      end
    end
  endtask
  task automatic t_enter4;
    wr(8'h00, 32'h0);
    host.frame(ENTER4, 32'h0, 0);
    send(8'h03, 32'h00123456, 32'h00123456, 32, FEAD_KIND_READ);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h80);
    host.frame(ENTER4, 32'h0, 0);
    wr(8'h00, 32'h0);
    send(8'h03, 32'h00123456, 32'h00123456, 24, FEAD_KIND_READ);
  endtask
  task automatic t_stream;
    for (int b = 0; b < 2; b++) begin
      wr(8'h00, 32'(b));
      // bytes only count while the frame is still selected
      fork
        send(8'h03, 32'hFFFFFF, {7'h0, b[0], 24'hFFFFFF}, 24, FEAD_KIND_READ);
        begin
          @(posedge clock iff cmd_valid);
          `CHK("start", {7'h0, b[0], 24'hFFFFFF}, seq_addr)
          data_byte_done <= 1'b1;
          @(posedge clock) data_byte_done <= 1'b0;
        end
      join
      `CHK("next", b ? 32'h0 : 32'h01000000, seq_addr)
      rd(8'h00);
      `CHK("bank kept", 32'(b), rdat)
    end
  endtask
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs;
    t_ded_ops;
    t_std_ops;
    t_enter4;
    t_stream;
    stop_test;
  end
  initial begin
    #4000000;
    n_fail++;
    stop_test;
  end
endmodule
